// *** sbl_consts.vh ***
// Protocol byte values, addresses and counts for the serial RAM loader.
`ifndef SBL_CONSTS_VH
`define SBL_CONSTS_VH
`define SBL_SYNC_BYTE   8'h5A
`define SBL_CMD_RAM     8'h60
`define SBL_ERR_BAUD    8'h62
`define SBL_ERR_CMD     8'h63
`define SBL_ERR_FRAME   8'hA1
`define SBL_ERR_OVRUN   8'hA3
`define SBL_ERR_REPS    2'h2
`define SBL_ADDR_LAST   8'h03
`define SBL_BLANK_BASE  16'hFFE0
`define SBL_BLANK_LAST  8'h1F
`define SBL_BLANK_VAL   8'hFF
`define SBL_START_MARK  8'h3A
`define SBL_REC_DATA    8'h00
`define SBL_REC_END     8'h01
`endif

// *** sbl_csum.v ***
// Image checksum accumulator, kept apart so the algorithm can be swapped.
`timescale 1ns/1ps
module sbl_csum (
  input  wire        CLK_I,
  input  wire        RSTN_I,
  input  wire        add_i,
  input  wire [7:0]  data_i,
  output wire [15:0] sum_o
);
  reg [15:0] sum_ff;

  assign sum_o = sum_ff;

  // Plain 16-bit sum of every byte written into RAM; replace this body as needed.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      sum_ff <= 16'h0000;
    else if (add_i)
      sum_ff <= sum_ff + {8'h00, data_i};
  end
endmodule

// *** sbl_fifo2.v ***
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sbl_fifo2 #(
  parameter W  = 8,
  parameter AW = 1
) (
  input  wire         CLK_I,
  input  wire         RSTN_I,
  input  wire [W-1:0] in_data_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  output wire [W-1:0] out_data_o,
  output wire         out_valid_o,
  input  wire         out_ready_i
);
  reg [W-1:0] mem_ff [0:(1<<AW)-1];
  reg [AW:0]  wr_ff;
  reg [AW:0]  rd_ff;
  wire        empty;
  wire        full;

  // The extra pointer bit tells a full buffer from an empty one.
  assign empty       = (wr_ff == rd_ff);
  assign full        = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

  // Pointers move only on an accepted handshake, so a stalled reader loses nothing.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid_i && !full)
        wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
      if (out_ready_i && !empty)
        rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage has no reset; a slot is read only after it was written.
  always @(posedge CLK_I)
  begin
    if (in_valid_i && !full)
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
  end
endmodule

// *** sbl_host_mdl.sv ***
// Far-side model: byte transmitter sink and RAM behind the loader.
`timescale 1ns/1ps
module sbl_host_mdl (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  output wire logic        tx_ready_o,
  output wire logic        tx_idle_o,
  input  wire logic        stall_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o = 8'h00
);
  logic [7:0] mem [0:65535];
  logic [7:0] got [$];
  logic [2:0] busy_ff;

  // A byte on the line keeps the shifter busy, so a byte that follows another is never taken instantly.
  assign tx_idle_o  = (busy_ff == 3'h0);
  assign tx_ready_o = tx_idle_o && !stall_i;

  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      busy_ff <= 3'h0;
    else if (tx_valid_i && tx_ready_o)
    begin
      got.push_back(tx_data_i);
      busy_ff <= 3'h4;
    end
    else if (busy_ff != 3'h0)
      busy_ff <= busy_ff - 3'h1;

  // RAM write and read
  // Outside the read slot the data toggles, so a late sample cannot match.
  always @(posedge clk_i)
  begin
    if (mem_wr_i)
      mem[mem_addr_i] <= mem_wdata_i;
    mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
  end
endmodule

// *** sbl_loader.v ***
// Serial boot RAM loader command interpreter.
// How it works
// RL1: Sync 5AH is echoed; anything else gets no answer.
// RL2: Valid baud code is echoed; bad code sends error byte three times, halts.
// RL3: Command 60H is echoed; other commands send 63H three times, halt.
// RL4: Count address arrives high then low byte, with no reply.
// RL5: Comparison address arrives high then low byte, with no reply.
// RL6: Password bytes are never acknowledged.
// RL7: All FFH in FFE0H..FFFFH means blank, password compare skipped.
// RL8: Password error halts; only hardware reset restarts the loader.
// RL9: Read protection or any password error stops traffic and halts.
// RL10: Reception error during addresses or password halts.
// RL11: Controller must not send a lone end record after the password.
// RL12: Image bytes are never echoed.
// RL13: Bytes before start mark 3AH are discarded.
// RL14: Record parsed as length, address, type, data, checksum.
// RL15: Data bytes are written to RAM from the record address.
// RL16: Image checksum sent after error-free end record, upper byte first.
// RL17: Reception or format error in the image halts silently.
// RL18: Controller waits for both checksum bytes after the end record.
// RL19: After the checksum, jump to the first data record's address.
// RL20: New baud rate applies only after the baud echo has left.
// RL21: Controller repeats sync; device restarts baud detection on a miss.
// RL22: Controller sends 28H even when keeping the initial rate.
// RL23: Password compared with N bytes from comparison address; mismatch halts.
// RL24: Halted, the device drops all input and queues no new byte; bytes already buffered still go out.
// RL25: Image checksum algorithm lives in a replaceable sub-module.
`timescale 1ns/1ps
`include "sbl_consts.vh"
module sbl_loader (
  input  wire        CLK_I,
  input  wire        RSTN_I,
  input  wire [7:0]  RX_DATA_I,
  input  wire        RX_VALID_I,
  input  wire        RX_FRAME_ERR_I,
  input  wire        RX_OVRUN_ERR_I,
  output wire        RX_READY_O,
  output wire [7:0]  TX_DATA_O,
  output wire        TX_VALID_O,
  input  wire        TX_READY_I,
  input  wire        TX_IDLE_I,
  input  wire        BAUD_CODE_OK_I,
  input  wire        RDPROT_I,
  output wire        AUTOBAUD_RESTART_O,
  output wire [7:0]  BAUD_CODE_O,
  output wire        BAUD_APPLY_O,
  output wire [15:0] MEM_ADDR_O,
  output wire        MEM_RD_O,
  input  wire [7:0]  MEM_RDATA_I,
  output wire        MEM_WR_O,
  output wire [7:0]  MEM_WDATA_O,
  output wire        JUMP_O,
  output wire [15:0] JUMP_ADDR_O,
  output wire        HALT_O
);
  localparam S_SYNC  = 5'd0;
  localparam S_BAUD  = 5'd1;
  localparam S_BAUDW = 5'd2;
  localparam S_CMD   = 5'd3;
  localparam S_ADDR  = 5'd4;
  localparam S_PROT  = 5'd5;
  localparam S_RD    = 5'd6;
  localparam S_RDW   = 5'd7;
  localparam S_RDC   = 5'd8;
  localparam S_PWD   = 5'd9;
  localparam S_MARK  = 5'd10;
  localparam S_LEN   = 5'd11;
  localparam S_AH    = 5'd12;
  localparam S_AL    = 5'd13;
  localparam S_TYPE  = 5'd14;
  localparam S_DATA  = 5'd15;
  localparam S_CHK   = 5'd16;
  localparam S_SUMH  = 5'd17;
  localparam S_SUML  = 5'd18;
  localparam S_JUMPW = 5'd19;
  localparam S_DONE  = 5'd20;
  localparam S_ERR   = 5'd21;
  localparam S_HALT  = 5'd22;

  localparam K_BLANK = 2'd0;
  localparam K_COUNT = 2'd1;
  localparam K_PWD   = 2'd2;

  reg [4:0]  state_ff, nxt_state;
  reg [1:0]  kind_ff, nxt_kind;
  reg [7:0]  errc_ff, nxt_errc;
  reg [1:0]  reps_ff, nxt_reps;
  reg [7:0]  baud_ff, nxt_baud;
  reg [15:0] cnt_addr_ff, nxt_cnt_addr;
  reg [15:0] cmp_addr_ff, nxt_cmp_addr;
  reg [7:0]  idx_ff, nxt_idx;
  reg [7:0]  pwn_ff, nxt_pwn;
  reg [7:0]  pwb_ff, nxt_pwb;
  reg        blank_ff, nxt_blank;
  reg [7:0]  rlen_ff, nxt_rlen;
  reg [15:0] raddr_ff, nxt_raddr;
  reg [7:0]  rtype_ff, nxt_rtype;
  reg [7:0]  rsum_ff, nxt_rsum;
  reg [15:0] jaddr_ff, nxt_jaddr;
  reg        have_rec_ff, nxt_have_rec;
  reg [15:0] mem_addr_ff, nxt_mem_addr;
  reg        mem_rd_ff, nxt_mem_rd;
  reg        mem_wr_ff, nxt_mem_wr;
  reg [7:0]  mem_wdata_ff, nxt_mem_wdata;
  reg        apply_ff, nxt_apply;
  reg        jump_ff, nxt_jump;
  reg        restart_ff, nxt_restart;
  reg        halt_ff;
  reg        rx_ready, push, csum_add;
  reg [7:0]  push_data;

  wire       f_rdy, rx_take, rx_err, tx_drained;
  wire [7:0] rsum_add, idx_inc;
  wire [15:0] img_sum;

  assign rx_take    = RX_VALID_I & rx_ready;
  assign rx_err     = RX_FRAME_ERR_I | RX_OVRUN_ERR_I;
  assign tx_drained = ~TX_VALID_O & TX_IDLE_I;
  assign rsum_add   = rsum_ff + RX_DATA_I;
  assign idx_inc    = idx_ff + 8'h01;
  assign RX_READY_O = rx_ready;

  assign AUTOBAUD_RESTART_O = restart_ff;
  assign BAUD_CODE_O        = baud_ff;
  assign BAUD_APPLY_O       = apply_ff;
  assign MEM_ADDR_O         = mem_addr_ff;
  assign MEM_RD_O           = mem_rd_ff;
  assign MEM_WR_O           = mem_wr_ff;
  assign MEM_WDATA_O        = mem_wdata_ff;
  assign JUMP_O             = jump_ff;
  assign JUMP_ADDR_O        = jaddr_ff;
  assign HALT_O             = halt_ff;

  // Transmit bytes wait here, so a slow transmitter stalls the sequencer instead of losing bytes.
  sbl_fifo2 #(
    .W  (8),
    .AW (1)
  ) u_txbuf (
    .CLK_I       (CLK_I),
    .RSTN_I      (RSTN_I),
    .in_data_i   (push_data),
    .in_valid_i  (push),
    .in_ready_o  (f_rdy),
    .out_data_o  (TX_DATA_O),
    .out_valid_o (TX_VALID_O),
    .out_ready_i (TX_READY_I)
  );

  // RL25: swappable image sum
  sbl_csum u_csum (
    .CLK_I  (CLK_I),
    .RSTN_I (RSTN_I),
    .add_i  (csum_add),
    .data_i (RX_DATA_I),
    .sum_o  (img_sum)
  );

  // Sequencer: one received byte is taken per handshake and steers the next state.
  always @*
  begin
    nxt_state     = state_ff;
    nxt_kind      = kind_ff;
    nxt_errc      = errc_ff;
    nxt_reps      = reps_ff;
    nxt_baud      = baud_ff;
    nxt_cnt_addr  = cnt_addr_ff;
    nxt_cmp_addr  = cmp_addr_ff;
    nxt_idx       = idx_ff;
    nxt_pwn       = pwn_ff;
    nxt_pwb       = pwb_ff;
    nxt_blank     = blank_ff;
    nxt_rlen      = rlen_ff;
    nxt_raddr     = raddr_ff;
    nxt_rtype     = rtype_ff;
    nxt_rsum      = rsum_ff;
    nxt_jaddr     = jaddr_ff;
    nxt_have_rec  = have_rec_ff;
    nxt_mem_addr  = mem_addr_ff;
    nxt_mem_rd    = 1'b0;
    nxt_mem_wr    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_apply     = 1'b0;
    nxt_jump      = 1'b0;
    nxt_restart   = 1'b0;
    rx_ready      = 1'b1;
    push          = 1'b0;
    push_data     = RX_DATA_I;
    csum_add      = 1'b0;
    case (state_ff)
      S_SYNC:
      begin
        rx_ready = f_rdy;
        // RL1: echo sync or stay silent
        if (rx_take && !rx_err && RX_DATA_I == `SBL_SYNC_BYTE)
        begin
          push      = 1'b1;
          nxt_state = S_BAUD;
        end
        else if (rx_take)
          nxt_restart = 1'b1;
      end
      S_BAUD:
      begin
        rx_ready = f_rdy;
        // RL2: baud code check
        if (rx_take)
        begin
          nxt_state = S_ERR;
          if (RX_FRAME_ERR_I)
            nxt_errc = `SBL_ERR_FRAME;
          else if (RX_OVRUN_ERR_I)
            nxt_errc = `SBL_ERR_OVRUN;
          else if (!BAUD_CODE_OK_I)
            nxt_errc = `SBL_ERR_BAUD;
          else
          begin
            push      = 1'b1;
            nxt_baud  = RX_DATA_I;
            nxt_state = S_BAUDW;
          end
        end
      end
      S_BAUDW:
      begin
        rx_ready = 1'b0;
        // RL20: switch rate after echo leaves
        if (tx_drained)
        begin
          nxt_apply = 1'b1;
          nxt_state = S_CMD;
        end
      end
      S_CMD:
      begin
        rx_ready = f_rdy;
        // RL3: accept only the loader command
        if (rx_take)
        begin
          nxt_state = S_ERR;
          nxt_idx   = 8'h00;
          if (RX_FRAME_ERR_I)
            nxt_errc = `SBL_ERR_FRAME;
          else if (RX_OVRUN_ERR_I)
            nxt_errc = `SBL_ERR_OVRUN;
          else if (RX_DATA_I != `SBL_CMD_RAM)
            nxt_errc = `SBL_ERR_CMD;
          else
          begin
            push      = 1'b1;
            nxt_state = S_ADDR;
          end
        end
      end
      S_ADDR:
      begin
        // RL4: count address, silent
        // RL5: comparison address, silent
        if (rx_take)
        begin
          // RL10: error in address halts
          if (rx_err)
            nxt_state = S_HALT;
          else
          begin
            {nxt_cnt_addr, nxt_cmp_addr} = {cnt_addr_ff[7:0], cmp_addr_ff, RX_DATA_I};
            nxt_idx = idx_inc;
            if (idx_ff == `SBL_ADDR_LAST)
              nxt_state = S_PROT;
          end
        end
      end
      S_PROT:
      begin
        rx_ready  = 1'b0;
        nxt_idx   = 8'h00;
        nxt_kind  = K_BLANK;
        nxt_blank = 1'b1;
        // RL9: read protection halts
        if (RDPROT_I)
          nxt_state = S_HALT;
        else
          nxt_state = S_RD;
      end
      S_RD:
      begin
        rx_ready   = 1'b0;
        nxt_mem_rd = 1'b1;
        nxt_state  = S_RDW;
        if (kind_ff == K_BLANK)
          nxt_mem_addr = `SBL_BLANK_BASE + {8'h00, idx_ff};
        else if (kind_ff == K_COUNT)
          nxt_mem_addr = cnt_addr_ff;
        else
          nxt_mem_addr = cmp_addr_ff + {8'h00, idx_ff};
      end
      S_RDW:
      begin
        rx_ready  = 1'b0;
        nxt_state = S_RDC;
      end
      S_RDC:
      begin
        rx_ready = 1'b0;
        nxt_idx  = idx_inc;
        nxt_state = S_RD;
        if (kind_ff == K_BLANK)
        begin
          // RL7: blank area skips compare
          nxt_blank = blank_ff & (MEM_RDATA_I == `SBL_BLANK_VAL);
          if (idx_ff == `SBL_BLANK_LAST)
          begin
            nxt_kind = K_COUNT;
            if (nxt_blank)
              nxt_state = S_MARK;
          end
        end
        else if (kind_ff == K_COUNT)
        begin
          nxt_pwn   = MEM_RDATA_I;
          nxt_idx   = 8'h00;
          nxt_state = (MEM_RDATA_I == 8'h00) ? S_MARK : S_PWD;
        end
        else
        begin
          // RL23: byte compare, silent halt
          // RL8: password error halts
          if (MEM_RDATA_I != pwb_ff)
            nxt_state = S_HALT;
          else if (idx_inc == pwn_ff)
            nxt_state = S_MARK;
          else
            nxt_state = S_PWD;
        end
      end
      S_PWD:
      begin
        // RL6: password byte, no reply
        if (rx_take)
        begin
          nxt_pwb   = RX_DATA_I;
          nxt_kind  = K_PWD;
          // RL10: error in password halts
          nxt_state = rx_err ? S_HALT : S_RD;
        end
      end
      S_MARK:
      begin
        // RL12: nothing is echoed here
        // RL13: wait for start mark
        nxt_rsum = 8'h00;
        if (rx_take && rx_err)
          nxt_state = S_HALT;
        else if (rx_take && RX_DATA_I == `SBL_START_MARK)
          nxt_state = S_LEN;
      end
      S_LEN, S_AH, S_AL, S_TYPE, S_DATA, S_CHK:
      begin
        // RL14: ordered record fields
        if (rx_take)
        begin
          nxt_rsum = rsum_add;
          // RL17: silent halt on image error
          if (rx_err)
            nxt_state = S_HALT;
          else if (state_ff == S_LEN)
          begin
            nxt_rlen  = RX_DATA_I;
            nxt_state = S_AH;
          end
          else if (state_ff == S_AH)
          begin
            nxt_raddr = {RX_DATA_I, raddr_ff[7:0]};
            nxt_state = S_AL;
          end
          else if (state_ff == S_AL)
          begin
            nxt_raddr = {raddr_ff[15:8], RX_DATA_I};
            nxt_state = S_TYPE;
          end
          else if (state_ff == S_TYPE)
          begin
            nxt_rtype = RX_DATA_I;
            nxt_idx   = 8'h00;
            if (RX_DATA_I == `SBL_REC_DATA)
              nxt_state = (rlen_ff == 8'h00) ? S_CHK : S_DATA;
            else if (RX_DATA_I == `SBL_REC_END && rlen_ff == 8'h00)
              nxt_state = S_CHK;
            else
              nxt_state = S_HALT;
          end
          else if (state_ff == S_DATA)
          begin
            // RL15: store at record address
            nxt_mem_wr    = 1'b1;
            nxt_mem_addr  = raddr_ff + {8'h00, idx_ff};
            nxt_mem_wdata = RX_DATA_I;
            csum_add      = 1'b1;
            nxt_idx       = idx_inc;
            if (idx_inc == rlen_ff)
              nxt_state = S_CHK;
          end
          else if (rsum_add != 8'h00)
            nxt_state = S_HALT;
          else if (rtype_ff == `SBL_REC_END)
            nxt_state = S_SUMH;
          else
          begin
            // RL19: remember first record address
            if (!have_rec_ff)
              nxt_jaddr = raddr_ff;
            nxt_have_rec = 1'b1;
            nxt_state    = S_MARK;
          end
        end
      end
      S_SUMH:
      begin
        rx_ready = 1'b0;
        // RL16: upper checksum byte first
        push      = f_rdy;
        push_data = img_sum[15:8];
        if (f_rdy)
          nxt_state = S_SUML;
      end
      S_SUML:
      begin
        rx_ready  = 1'b0;
        push      = f_rdy;
        push_data = img_sum[7:0];
        if (f_rdy)
          nxt_state = S_JUMPW;
      end
      S_JUMPW:
      begin
        rx_ready = 1'b0;
        // RL19: jump once both bytes left
        if (tx_drained)
        begin
          nxt_jump  = 1'b1;
          nxt_state = S_DONE;
        end
      end
      S_ERR:
      begin
        rx_ready  = 1'b0;
        push      = f_rdy;
        push_data = errc_ff;
        // RL2: error byte sent three times
        if (f_rdy)
        begin
          nxt_reps = reps_ff + 2'h1;
          if (reps_ff == `SBL_ERR_REPS)
            nxt_state = S_HALT;
        end
      end
      S_DONE:
        nxt_state = S_DONE;
      S_HALT:
        // RL24: drop input, queue nothing new
        nxt_state = S_HALT;
      default:
        nxt_state = S_HALT;
    endcase
  end

  // All control state clears on reset; the halt state is left only through reset.
  always @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_ff     <= S_SYNC;
      kind_ff      <= K_BLANK;
      errc_ff      <= 8'h00;
      reps_ff      <= 2'h0;
      baud_ff      <= 8'h00;
      cnt_addr_ff  <= 16'h0000;
      cmp_addr_ff  <= 16'h0000;
      idx_ff       <= 8'h00;
      pwn_ff       <= 8'h00;
      pwb_ff       <= 8'h00;
      blank_ff     <= 1'b0;
      rlen_ff      <= 8'h00;
      raddr_ff     <= 16'h0000;
      rtype_ff     <= 8'h00;
      rsum_ff      <= 8'h00;
      jaddr_ff     <= 16'h0000;
      have_rec_ff  <= 1'b0;
      mem_addr_ff  <= 16'h0000;
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= 8'h00;
      apply_ff     <= 1'b0;
      jump_ff      <= 1'b0;
      restart_ff   <= 1'b0;
      halt_ff      <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      kind_ff      <= nxt_kind;
      errc_ff      <= nxt_errc;
      reps_ff      <= nxt_reps;
      baud_ff      <= nxt_baud;
      cnt_addr_ff  <= nxt_cnt_addr;
      cmp_addr_ff  <= nxt_cmp_addr;
      idx_ff       <= nxt_idx;
      pwn_ff       <= nxt_pwn;
      pwb_ff       <= nxt_pwb;
      blank_ff     <= nxt_blank;
      rlen_ff      <= nxt_rlen;
      raddr_ff     <= nxt_raddr;
      rtype_ff     <= nxt_rtype;
      rsum_ff      <= nxt_rsum;
      jaddr_ff     <= nxt_jaddr;
      have_rec_ff  <= nxt_have_rec;
      mem_addr_ff  <= nxt_mem_addr;
      mem_rd_ff    <= nxt_mem_rd;
      mem_wr_ff    <= nxt_mem_wr;
      mem_wdata_ff <= nxt_mem_wdata;
      apply_ff     <= nxt_apply;
      jump_ff      <= nxt_jump;
      restart_ff   <= nxt_restart;
      halt_ff      <= (nxt_state == S_HALT);
    end
  end
endmodule

// *** sbl_loader_props.sv ***
// Concurrent checks on the ports of the serial boot RAM loader.
`timescale 1ns/1ps
module sbl_loader_chk (
  input wire logic       CLK_I,
  input wire logic       RSTN_I,
  input wire logic       RX_VALID_I,
  input wire logic       RX_READY_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic       TX_VALID_O,
  input wire logic       TX_READY_I,
  input wire logic       TX_IDLE_I,
  input wire logic       AUTOBAUD_RESTART_O,
  input wire logic       BAUD_APPLY_O,
  input wire logic       MEM_RD_O,
  input wire logic       MEM_WR_O,
  input wire logic       JUMP_O,
  input wire logic       HALT_O
);
  // All checks share the one clock and drop out while reset is low.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  halt_sticky_a: assert property (HALT_O |=> HALT_O)
    else $error("halt dropped without reset");
  halt_quiet_a: assert property (HALT_O |-> !MEM_WR_O && !JUMP_O && !BAUD_APPLY_O)
    else $error("activity while halted");
  halt_no_tx_a: assert property (HALT_O && !TX_VALID_O |=> !TX_VALID_O)
    else $error("new byte sent while halted");
  restart_quiet_a: assert property (AUTOBAUD_RESTART_O |-> !TX_VALID_O && $past(RX_VALID_I && RX_READY_O))
    else $error("restart without taken byte or with echo");
  apply_idle_a: assert property (BAUD_APPLY_O |-> $past(TX_IDLE_I) && !TX_VALID_O)
    else $error("rate switched before echo left");
  apply_once_a: assert property (BAUD_APPLY_O |=> !BAUD_APPLY_O [*8])
    else $error("rate switch repeated");
  jump_idle_a: assert property (JUMP_O |-> $past(TX_IDLE_I) && !TX_VALID_O && !HALT_O)
    else $error("jump before checksum left");
  jump_once_a: assert property (JUMP_O |=> (!JUMP_O && !MEM_WR_O && !TX_VALID_O) [*8])
    else $error("activity after jump");
  wr_cause_a: assert property (MEM_WR_O |-> $past(RX_VALID_I && RX_READY_O))
    else $error("write without a taken byte");
  rd_gap_a: assert property (MEM_RD_O |=> !MEM_RD_O [*2])
    else $error("reads too close");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("stalled byte lost or changed");
endmodule

bind sbl_loader sbl_loader_chk chk_u (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .RX_VALID_I(RX_VALID_I), .RX_READY_O(RX_READY_O),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I), .TX_IDLE_I(TX_IDLE_I),
  .AUTOBAUD_RESTART_O(AUTOBAUD_RESTART_O), .BAUD_APPLY_O(BAUD_APPLY_O), .MEM_RD_O(MEM_RD_O),
  .MEM_WR_O(MEM_WR_O), .JUMP_O(JUMP_O), .HALT_O(HALT_O)
);

// *** sbl_tb.sv ***
// Self-checking bench for the serial boot RAM loader.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  logic        CLK_I = 1'h0;
  logic        RSTN_I = 1'h0;
  logic [7:0]  RX_DATA_I = 8'h00;
  logic        RX_VALID_I = 1'h0;
  logic        RX_FRAME_ERR_I = 1'h0;
  logic        RX_OVRUN_ERR_I = 1'h0;
  logic        RDPROT_I = 1'h0;
  logic        stall = 1'h0;
  wire         RX_READY_O, TX_VALID_O, TX_READY_I, TX_IDLE_I, AUTOBAUD_RESTART_O, BAUD_APPLY_O;
  wire         MEM_RD_O, MEM_WR_O, JUMP_O, HALT_O;
  wire [7:0]   TX_DATA_O, BAUD_CODE_O, MEM_RDATA_I, MEM_WDATA_O;
  wire [15:0]  MEM_ADDR_O, JUMP_ADDR_O;
  wire         BAUD_CODE_OK_I = (RX_DATA_I == 8'h28) || (RX_DATA_I == 8'h18);
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          restarts = 0;

  sbl_loader dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .RX_DATA_I(RX_DATA_I), .RX_VALID_I(RX_VALID_I),
    .RX_FRAME_ERR_I(RX_FRAME_ERR_I), .RX_OVRUN_ERR_I(RX_OVRUN_ERR_I), .RX_READY_O(RX_READY_O),
    .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I), .TX_IDLE_I(TX_IDLE_I),
    .BAUD_CODE_OK_I(BAUD_CODE_OK_I), .RDPROT_I(RDPROT_I), .AUTOBAUD_RESTART_O(AUTOBAUD_RESTART_O),
    .BAUD_CODE_O(BAUD_CODE_O), .BAUD_APPLY_O(BAUD_APPLY_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O),
    .MEM_RDATA_I(MEM_RDATA_I), .MEM_WR_O(MEM_WR_O), .MEM_WDATA_O(MEM_WDATA_O), .JUMP_O(JUMP_O),
    .JUMP_ADDR_O(JUMP_ADDR_O), .HALT_O(HALT_O));

  sbl_host_mdl pm_u (.clk_i(CLK_I), .rstn_i(RSTN_I), .tx_data_i(TX_DATA_O), .tx_valid_i(TX_VALID_O),
    .tx_ready_o(TX_READY_I), .tx_idle_o(TX_IDLE_I), .stall_i(stall), .mem_addr_i(MEM_ADDR_O),
    .mem_rd_i(MEM_RD_O), .mem_wr_i(MEM_WR_O), .mem_wdata_i(MEM_WDATA_O), .mem_rdata_o(MEM_RDATA_I));

  // Free-running clock at 100 MHz.
  initial
  begin
    forever #5 CLK_I = ~CLK_I;
  end

  // Count restart pulses and end a hung run as a failure.
  always @(posedge CLK_I)
  begin
    cyc++;
    if (AUTOBAUD_RESTART_O === 1'h1)
      restarts++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task automatic rst_dut;
    RSTN_I = 1'h0;
    repeat (20) @(posedge CLK_I);
    #1 RSTN_I = 1'h1;
    pm_u.got.delete();
  endtask

  // Offer one byte, hold it until taken, then leave one idle cycle.
  task automatic send(input logic [7:0] b, input logic fe = 1'h0, input logic oe = 1'h0);
    int i;
    logic r;
    RX_DATA_I = b;
    RX_FRAME_ERR_I = fe;
    RX_OVRUN_ERR_I = oe;
    RX_VALID_I = 1'h1;
    for (i = 0; i < 400; i++)
    begin
      @(negedge CLK_I);
      r = RX_READY_O;
      @(posedge CLK_I);
      if (r === 1'h1)
        break;
    end
    if (i == 400) `CHK(1'h0, 1'h1)
    #1 RX_VALID_I = 1'h0;
    RX_FRAME_ERR_I = 1'h0;
    RX_OVRUN_ERR_I = 1'h0;
    tick(1);
  endtask

  // start mark, length, address, type, data, checksum
  task automatic rec(input logic [15:0] a, input logic [7:0] t, input logic [7:0] d0, input logic [7:0] d1,
                     input int n, input logic bad);
    logic [7:0] s;
    s = n[7:0] + a[15:8] + a[7:0] + t + (n > 0 ? d0 : 8'h00) + (n > 1 ? d1 : 8'h00);
    send(8'h3A);
    send(n[7:0]);
    send(a[15:8]);
    send(a[7:0]);
    send(t);
    if (n > 0)
      send(d0);
    if (n > 1)
      send(d1);
    send(8'h00 - s + {7'h00, bad});
  endtask

  task automatic t_sync;
    restarts = 0;
    rst_dut;
    send(8'h5A, 1'h1);
    send(8'h00);
    tick(5);
    `CHK(restarts, 2)
    `CHK(pm_u.got.size(), 0)
    send(8'h5A);
    tick(10);
    `CHK(pm_u.got[0], 8'h5A)
    $display("test sync done");
  endtask

  // Error codes with the transmitter stalled, so the full buffer must hold the third code back.
  task automatic t_err(input int c);
    logic [7:0] code;
    int n0;
    int i;
    code = (c == 0) ? 8'h62 : (c == 3) ? 8'h63 : (c == 2) ? 8'hA3 : 8'hA1;
    n0 = (c < 3) ? 1 : 2;
    rst_dut;
    send(8'h5A);
    if (c > 2)
    begin
      send(8'h28);
      tick(20);
    end
    stall = 1'h1;
    case (c)
      0: send(8'h33);
      1: send(8'h28, 1'h1);
      2: send(8'h28, 1'h0, 1'h1);
      3: send(8'h30);
      default: send(8'h60, 1'h1);
    endcase
    tick(10);
    `CHK(HALT_O, 1'h0)
    stall = 1'h0;
    tick(40);
    `CHK(HALT_O, 1'h1)
    `CHK(pm_u.got.size(), n0 + 3)
    for (i = 0; i < 3; i++) `CHK(pm_u.got[n0 + i], code)
    $display("test error %0d done", c);
  endtask

  // Cases 0..3 halt (protection, password, address byte, record); 4 and 5 load.
  task automatic t_load(input int k);
    int i;
    rst_dut;
    for (i = 0; i < 32; i++) pm_u.mem[16'hFFE0 + i] = 8'hFF;
    if (k != 5)
      pm_u.mem[16'hFFE0] = 8'h00;
    pm_u.mem[16'h0100] = 8'h02;
    pm_u.mem[16'h0200] = 8'h50;
    pm_u.mem[16'h0201] = 8'h57;
    RDPROT_I = (k == 0);
    // rate code sent even at the initial rate
    send(8'h5A);
    send(8'h28);
    send(8'h60);
    send(8'h01);
    send(8'h00);
    send(8'h02);
    send(8'h00, k == 2);
    if (k != 5)
    begin
      send(8'h50);
      send(k == 1 ? 8'h00 : 8'h57);
    end
    send(8'h11);
    // data records precede the end record
    rec(16'h1234, 8'h00, 8'hAA, 8'h55, 2, k == 3);
    rec(16'h2000, 8'h00, 8'h01, 8'h00, 1, 1'h0);
    rec(16'h0000, 8'h01, 8'h00, 8'h00, 0, 1'h0);
    for (i = 0; i < 300 && JUMP_O !== 1'h1 && HALT_O !== 1'h1; i++) tick(1);
    `CHK({pm_u.got[0], pm_u.got[1], pm_u.got[2]}, 24'h5A2860)
    `CHK(HALT_O, k < 4)
    if (k > 3)
    begin
      `CHK(JUMP_O, 1'h1)
      `CHK(JUMP_ADDR_O, 16'h1234)
      `CHK({pm_u.got[3], pm_u.got[4]}, 16'h00AA + 16'h0055 + 16'h0001)
      `CHK({pm_u.mem[16'h1234], pm_u.mem[16'h1235], pm_u.mem[16'h2000]}, 24'hAA5501)
      `CHK(BAUD_CODE_O, 8'h28)
    end
    send(8'h5A);
    tick(20);
    `CHK(pm_u.got.size(), (k < 4) ? 3 : 5)
    $display("test load %0d done", k);
  endtask

  // Main sequence.
  initial
  begin
    int k;
    rst_dut;
    t_sync;
    for (k = 0; k < 5; k++) t_err(k);
    for (k = 0; k < 6; k++) t_load(k);
    end_of_test;
  end
endmodule
